// ### rtl/adcsq_top.v
`timescale 1ns/100ps
`include "adcsq_map.vh"
module adcsq_top #(
	parameter DIV_W = 4
) (
	// Clock and reset
	input wire CLK_I,
	input wire RST_B_I,
	// Register port
	input wire [4:0] ADDR_I,
	input wire [15:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	output reg [15:0] RDATA_O,
	// Power mode
	input wire STOP_I,
	// Converter front end
	input wire [11:0] CONV_DATA_I,
	output reg [2:0] MUX_SEL_O,
	output reg DIFF_O,
	output reg EXT_REF_O,
	output reg FS_HIGH_O,
	output reg [1:0] BIAS_SEL_O,
	output reg SAMPLE_O,
	output reg CONV_PWR_O,
	output reg [15:0] GAIN_O,
	// Interrupt
	output reg IRQ_O
);
	localparam ST_OFF = 3'h0;
	localparam ST_WAKE = 3'h1;
	localparam ST_ACQ = 3'h2;
	localparam ST_CONV = 3'h3;
	localparam ST_NEXT = 3'h4;

	reg [15:0] ctrl_r;
	reg [10:0] cfg_r [0:7];
	reg [12:0] buf_r [0:15];
	reg [15:0] glo_r;
	reg [15:0] ghi_r;
	reg [1:0] stat_r;
	reg [1:0] ien_r;
	reg [2:0] state_r;
	reg [2:0] ch_r;
	reg [5:0] step_r;
	reg [1:0] pt_r;
	reg [3:0] wptr_r;
	reg [3:0] smp_r;
	reg [12:0] res_r;
	reg stop_a_r;
	reg stop_b_r;
	reg stop_c_r;
	reg stop_r;
	wire tick;
	wire [10:0] cfg_cur;
	wire is_temp;
	wire wr_ctrl;
	wire start_req;
	wire [5:0] acq_len;
	wire done;
	wire [12:0] res_fmt;
	integer i;

	assign cfg_cur = cfg_r[ch_r];
	// Temperature select
	// Channel six is forced to temperature whatever its field says.
	assign is_temp = cfg_cur[`ADCSQ_F_TEMP] || (cfg_cur[`ADCSQ_F_MUX_HI:`ADCSQ_F_MUX_LO] == `ADCSQ_DIE_CH);
	assign wr_ctrl = WR_I && (ADDR_I == `ADCSQ_A_CTRL);
	assign start_req = wr_ctrl && WDATA_I[`ADCSQ_C_START];
	// Acquisition extension
	// Extra steps come from the control field.
	assign acq_len = cfg_cur[`ADCSQ_F_ACQX] ?
		(6'd`ADCSQ_ACQ_BASE + {2'b00, ctrl_r[`ADCSQ_C_ACQ_HI:`ADCSQ_C_ACQ_LO]} * 6'd2) :
		6'd`ADCSQ_ACQ_BASE;
	assign done = tick && (state_r == ST_CONV) && (step_r == 6'd`ADCSQ_CONV_CYC - 6'd1);
	// Result format
	// The code sits in the low twelve bits, or in bits twelve to one when aligned.
	assign res_fmt = cfg_cur[`ADCSQ_F_ALIGN] ? {CONV_DATA_I, 1'b0} : {1'b0, CONV_DATA_I};

	// ----------------------------------------
	// Stop input synchroniser
	// ----------------------------------------
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			stop_a_r <= 1'b0;
			stop_b_r <= 1'b0;
			stop_c_r <= 1'b0;
			stop_r <= 1'b0;
		end else begin
			stop_a_r <= STOP_I;
			stop_b_r <= stop_a_r;
			stop_c_r <= stop_b_r;
			if (stop_b_r == stop_c_r)
				stop_r <= stop_c_r;
		end
	end

	// Converter clock
	// Ratio field sets the step rate.
	adcsq_clkdiv #(
		.W(DIV_W)
	) u_div (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.run_i(state_r != ST_OFF),
		.ratio_i(ctrl_r[`ADCSQ_C_DIV_HI:`ADCSQ_C_DIV_LO]),
		.tick_o(tick)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state_r <= ST_OFF;
			ch_r <= 3'h0;
			step_r <= 6'h00;
			pt_r <= 2'h0;
			res_r <= 13'h0000;
		end else if (stop_r) begin
			// Stop abort
			// Any conversion in flight is dropped.
			state_r <= ST_OFF;
			step_r <= 6'h00;
		end else if (start_req) begin
			// Wake delay
			// Every start outside stop begins with the settle count.
			state_r <= ST_WAKE;
			ch_r <= 3'h0;
			step_r <= 6'h00;
			pt_r <= 2'h0;
		end else if (tick) begin
			case (state_r)
				ST_WAKE: begin
					// Wake delay
					// Twenty converter clocks before acquiring.
					if (step_r == 6'd`ADCSQ_WAKE_CYC - 6'd1) begin
						// An enabled first channel acquires at once, so the twentieth tick is the last idle one.
						state_r <= cfg_cur[`ADCSQ_F_EN] ? ST_ACQ : ST_NEXT;
						step_r <= 6'h00;
					end else
						step_r <= step_r + 6'd1;
				end
				ST_NEXT: begin
					if (cfg_cur[`ADCSQ_F_EN])
						state_r <= ST_ACQ;
					else if (ch_r == 3'h7)
						state_r <= ctrl_r[`ADCSQ_C_CONT] ? ST_NEXT : ST_OFF;
					if (!cfg_cur[`ADCSQ_F_EN])
						ch_r <= ch_r + 3'h1;
				end
				ST_ACQ: begin
					if (step_r == acq_len - 6'd1) begin
						state_r <= ST_CONV;
						step_r <= 6'h00;
					end else
						step_r <= step_r + 6'd1;
				end
				ST_CONV: begin
					// Conversion length
					// Thirty-four steps per conversion.
					if (step_r == 6'd`ADCSQ_CONV_CYC - 6'd1) begin
						step_r <= 6'h00;
						res_r <= res_fmt;
						// Diode points
						// Three bias points per temperature sample.
						if (is_temp && pt_r != 2'd`ADCSQ_TEMP_PTS - 2'd1) begin
							pt_r <= pt_r + 2'h1;
							state_r <= ST_ACQ;
						end else begin
							pt_r <= 2'h0;
							ch_r <= ch_r + 3'h1;
							// Sequence end
							// Single mode shuts down after the last channel.
							if (ch_r == 3'h7 && !ctrl_r[`ADCSQ_C_CONT])
								state_r <= ST_OFF;
							else
								state_r <= ST_NEXT;
						end
					end else
						step_r <= step_r + 6'd1;
				end
				default: state_r <= ST_OFF;
			endcase
		end
	end

	// ----------------------------------------
	// Buffer, count and flags
	// ----------------------------------------
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			wptr_r <= 4'h0;
			smp_r <= 4'h0;
			stat_r <= 2'b00;
			for (i = 0; i < 16; i = i + 1)
				buf_r[i] <= 13'h0000;
		end else begin
			// Clear comes first so that an event in the same cycle still sets its bit.
			if (WR_I && ADDR_I == `ADCSQ_A_ICLR)
				stat_r <= stat_r & ~WDATA_I[1:0];
			if (done && !stop_r && !start_req && !(is_temp && pt_r != 2'd`ADCSQ_TEMP_PTS - 2'd1)) begin
				// Circular store
				// Store and wrap naturally at sixteen.
				buf_r[wptr_r] <= res_fmt;
				wptr_r <= wptr_r + 4'h1;
				// Sample count
				// Flag sets regardless of its enable.
				if (smp_r == ctrl_r[`ADCSQ_C_CNT_HI:`ADCSQ_C_CNT_LO]) begin
					smp_r <= 4'h0;
					stat_r[`ADCSQ_S_DATA] <= 1'b1;
				end else
					smp_r <= smp_r + 4'h1;
				if (ch_r == 3'h7)
					stat_r[`ADCSQ_S_DONE] <= 1'b1;
			end else if (start_req) begin
				// Flag release
				// A fresh start clears the data flag.
				stat_r[`ADCSQ_S_DATA] <= 1'b0;
				smp_r <= 4'h0;
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ctrl_r <= `ADCSQ_CTRL_RST;
			ien_r <= 2'b00;
			glo_r <= `ADCSQ_GAIN_RST;
			ghi_r <= `ADCSQ_GAIN_RST;
			for (i = 0; i < 8; i = i + 1)
				cfg_r[i] <= 11'h000;
		end else begin
			if (wr_ctrl)
				ctrl_r <= WDATA_I;
			// Start bit release
			// Stop forces the start bit low; it also drops when a run ends.
			if (stop_r || (state_r == ST_OFF && !start_req))
				ctrl_r[`ADCSQ_C_START] <= 1'b0;
			if (WR_I && ADDR_I == `ADCSQ_A_IEN)
				ien_r <= WDATA_I[1:0];
			if (WR_I && ADDR_I == `ADCSQ_A_GLO)
				glo_r <= WDATA_I;
			if (WR_I && ADDR_I == `ADCSQ_A_GHI)
				ghi_r <= WDATA_I;
			// Channel configuration
			// Eight words at offsets eight to fifteen.
			if (WR_I && ADDR_I[4:3] == 2'b01)
				cfg_r[ADDR_I[2:0]] <= WDATA_I[10:0];
		end
	end

	// ----------------------------------------
	// Read port and outputs
	// ----------------------------------------
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			RDATA_O <= 16'h0000;
			MUX_SEL_O <= 3'h0;
			DIFF_O <= 1'b0;
			EXT_REF_O <= 1'b0;
			FS_HIGH_O <= 1'b0;
			BIAS_SEL_O <= 2'h0;
			SAMPLE_O <= 1'b0;
			CONV_PWR_O <= 1'b0;
			GAIN_O <= `ADCSQ_GAIN_RST;
			IRQ_O <= 1'b0;
		end else begin
			RDATA_O <= 16'h0000;
			if (RD_I) begin
				if (ADDR_I[4])
					RDATA_O <= {3'h0, buf_r[ADDR_I[3:0]]};
				else if (ADDR_I[3])
					RDATA_O <= {5'h00, cfg_r[ADDR_I[2:0]]};
				else begin
					case (ADDR_I[2:0])
						3'h0: RDATA_O <= ctrl_r;
						3'h1: RDATA_O <= {state_r, wptr_r, 7'h00, stat_r};
						3'h3: RDATA_O <= {14'h0000, ien_r};
						3'h4: RDATA_O <= glo_r;
						3'h5: RDATA_O <= ghi_r;
						3'h6: RDATA_O <= {3'h0, res_r};
						default: RDATA_O <= 16'h0000;
					endcase
				end
			end
			// Selector drive
			// Channel and pairing from configuration.
			MUX_SEL_O <= cfg_cur[`ADCSQ_F_MUX_HI:`ADCSQ_F_MUX_LO];
			DIFF_O <= cfg_cur[`ADCSQ_F_DIFF] && !is_temp;
			// Reference choice
			// Temperature forces internal reference at low range.
			EXT_REF_O <= cfg_cur[`ADCSQ_F_EXTREF] && !is_temp;
			FS_HIGH_O <= cfg_cur[`ADCSQ_F_FS5] && !is_temp && !cfg_cur[`ADCSQ_F_EXTREF];
			GAIN_O <= (cfg_cur[`ADCSQ_F_FS5] && !is_temp) ? ghi_r : glo_r;
			BIAS_SEL_O <= is_temp ? pt_r : 2'h0;
			SAMPLE_O <= (state_r == ST_ACQ);
			// Power down
			// Converter off while idle or stopped.
			CONV_PWR_O <= (state_r != ST_OFF) && !stop_r;
			// Interrupt line
			// Enabled sticky bits drive the level.
			IRQ_O <= |(stat_r & ien_r);
		end
	end
endmodule

// ### common/adcsq_map.vh
`ifndef ADCSQ_MAP_VH
`define ADCSQ_MAP_VH
// ----------------------------------------
// Register offsets (word index on the plain port)
// ----------------------------------------
`define ADCSQ_A_CTRL 5'h00
`define ADCSQ_A_STAT 5'h01
`define ADCSQ_A_ICLR 5'h02
`define ADCSQ_A_IEN 5'h03
`define ADCSQ_A_GLO 5'h04
`define ADCSQ_A_GHI 5'h05
`define ADCSQ_A_RESULT 5'h06
`define ADCSQ_A_CFG0 5'h08
`define ADCSQ_A_BUF0 5'h10
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define ADCSQ_C_START 0
`define ADCSQ_C_CONT 1
`define ADCSQ_C_DIV_LO 2
`define ADCSQ_C_DIV_HI 5
`define ADCSQ_C_ACQ_LO 6
`define ADCSQ_C_ACQ_HI 9
`define ADCSQ_C_CNT_LO 10
`define ADCSQ_C_CNT_HI 13
// ----------------------------------------
// Channel configuration fields
// ----------------------------------------
`define ADCSQ_F_DIFF 0
`define ADCSQ_F_ALIGN 1
`define ADCSQ_F_ACQX 2
`define ADCSQ_F_EXTREF 3
`define ADCSQ_F_TEMP 4
`define ADCSQ_F_FS5 5
`define ADCSQ_F_EN 6
`define ADCSQ_F_MUX_LO 8
`define ADCSQ_F_MUX_HI 10
// ----------------------------------------
// Status bits and reset values
// ----------------------------------------
`define ADCSQ_S_DATA 0
`define ADCSQ_S_DONE 1
`define ADCSQ_CTRL_RST 16'h0000
`define ADCSQ_GAIN_RST 16'h8000
// ----------------------------------------
// Timing in converter clocks, then divider floor in system clocks, diode points and die channel
// ----------------------------------------
`define ADCSQ_CONV_CYC 34
`define ADCSQ_WAKE_CYC 20
`define ADCSQ_ACQ_BASE 4
`define ADCSQ_MIN_DIV 16
`define ADCSQ_TEMP_PTS 3
`define ADCSQ_DIE_CH 3'h6
`endif

// ### rtl/adcsq_clkdiv.v
`timescale 1ns/100ps
module adcsq_clkdiv #(
	parameter W = 4
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_b_i,
	// Control
	input wire run_i,
	input wire [W-1:0] ratio_i,
	// Enable out
	output reg tick_o
);
	reg [W+4:0] cnt_r;
	wire [W+4:0] lim;
	// ----------------------------------------
	// Converter clock enable
	// ----------------------------------------
	// Sixteen system clocks per step at least, so 34 steps give the 544 clock floor.
	assign lim = {ratio_i, 4'h0} + 5'h0f;
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r <= {(W+5){1'b0}};
			tick_o <= 1'b0;
		end else if (!run_i) begin
			cnt_r <= {(W+5){1'b0}};
			tick_o <= 1'b0;
		end else begin
			tick_o <= (cnt_r == lim);
			if (cnt_r == lim)
				cnt_r <= {(W+5){1'b0}};
			else
				cnt_r <= cnt_r + 1'b1;
		end
	end
endmodule

// ### bench/adcsq_asserts.sv
`timescale 1ns/100ps
`include "adcsq_map.vh"
module adcsq_asserts (
	// Clock, reset and register port
	input wire CLK_I,
	input wire RST_B_I,
	input wire [4:0] ADDR_I,
	input wire [15:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	input wire [15:0] RDATA_O,
	// Stop and front end
	input wire STOP_I,
	input wire [2:0] MUX_SEL_O,
	input wire EXT_REF_O,
	input wire FS_HIGH_O,
	input wire SAMPLE_O,
	input wire CONV_PWR_O,
	input wire IRQ_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	a_read_quiet: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
		else $error("read data not zero outside a read");
	// Eight cycles leave room for the three-stage stop synchroniser.
	a_stop_off: assert property (STOP_I [*8] |-> !CONV_PWR_O)
		else $error("converter powered in stop");
	a_die_ref: assert property (SAMPLE_O && MUX_SEL_O == `ADCSQ_DIE_CH |-> !EXT_REF_O && !FS_HIGH_O)
		else $error("die channel not on internal low range");
	a_sample_pwr: assert property (SAMPLE_O |-> CONV_PWR_O)
		else $error("sampling while shut down");
	a_acq_min: assert property ($rose(SAMPLE_O) |-> SAMPLE_O [*8])
		else $error("acquisition too short");
	a_wake_gap: assert property ($rose(CONV_PWR_O) |-> (!SAMPLE_O) [*8])
		else $error("acquisition without wake delay");
	a_conv_gap: assert property ($fell(SAMPLE_O) && CONV_PWR_O |-> (!SAMPLE_O) [*8])
		else $error("acquisition inside conversion");
	a_irq_mask: assert property (WR_I && ADDR_I == `ADCSQ_A_IEN && WDATA_I == 16'h0000 |-> ##2 !IRQ_O)
		else $error("interrupt stays with enable cleared");
endmodule

// ### bench/adcsq_front.sv
`timescale 1ns/100ps
module adcsq_front (
	// Clock
	input wire clk_i,
	// Front end
	input wire pwr_i,
	input wire [2:0] mux_i,
	output reg [11:0] data_o
);
	// Outside a run the code toggles so no stale value passes as a result.
	initial data_o = 12'h000;
	always @(posedge clk_i) begin
		data_o <= pwr_i ? {1'b0, mux_i, 8'h5A} : ~data_o;
	end
endmodule

// ### bench/test_adcsq_top.sv
`timescale 1ns/100ps
`include "adcsq_map.vh"
module test_adcsq_top;
	reg CLK_I = 0, RST_B_I = 0, WR_I = 0, RD_I = 0, STOP_I = 0;
	reg [4:0] ADDR_I = 0;
	reg [15:0] WDATA_I = 0, q, w0;
	wire [15:0] RDATA_O, GAIN_O;
	wire [11:0] cd;
	wire [2:0] mux;
	wire [1:0] bias;
	wire dif, ext, fsh, SAMPLE_O, CONV_PWR_O, IRQ_O;
	integer fails = 0, compares = 0, cyc = 0, tr = 0, tf = 0, tp = 0, i, k;
	reg ps = 0, pp = 0;
	reg [37:0] rows [0:8];
	adcsq_top dut_u (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
		.RD_I(RD_I), .RDATA_O(RDATA_O), .STOP_I(STOP_I), .CONV_DATA_I(cd), .MUX_SEL_O(mux), .DIFF_O(dif),
		.EXT_REF_O(ext), .FS_HIGH_O(fsh), .BIAS_SEL_O(bias), .SAMPLE_O(SAMPLE_O), .CONV_PWR_O(CONV_PWR_O),
		.GAIN_O(GAIN_O), .IRQ_O(IRQ_O));
	adcsq_front front_u (.clk_i(CLK_I), .pwr_i(CONV_PWR_O), .mux_i(mux), .data_o(cd));
	initial begin
		forever #10 CLK_I = ~CLK_I;
	end
	always @(posedge CLK_I) begin
		cyc <= cyc + 1;
		ps <= SAMPLE_O;
		pp <= CONV_PWR_O;
		if (SAMPLE_O && !ps) tr <= cyc;
		if (!SAMPLE_O && ps) tf <= cyc;
		if (CONV_PWR_O && !pp) tp <= cyc;
		if (cyc == 40000) begin
			fails = fails + 1;
			conclude;
		end
	end
	task conclude;
		begin
			$display("compares %0d fails %0d", compares, fails);
			if (fails == 0 && compares > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input [8*6-1:0] n, input [15:0] e, input [15:0] g);
		begin
			compares = compares + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("CHECK FAILED %s exp %h got %h", n, e, g);
			end
		end
	endtask
	task wr(input [4:0] a, input [15:0] d);
		begin
			@(posedge CLK_I);
			ADDR_I <= a;
			WDATA_I <= d;
			WR_I <= 1;
			@(posedge CLK_I);
			WR_I <= 0;
		end
	endtask
	task rd(input [4:0] a);
		begin
			@(posedge CLK_I);
			ADDR_I <= a;
			RD_I <= 1;
			@(posedge CLK_I);
			RD_I <= 0;
			@(negedge CLK_I);
			q = RDATA_O;
		end
	endtask
	// One single sequence on channel config 0; tk is clocks per converter tick.
	task run(input [15:0] c, input [15:0] k, input integer tk, input integer acq);
		begin
			wr(`ADCSQ_A_CFG0, c);
			rd(`ADCSQ_A_STAT);
			w0 = q;
			wr(`ADCSQ_A_CTRL, k);
			rd(`ADCSQ_A_STAT);
			chk("newclr", 16'h0000, q[0]);
			q = 0;
			for (i = 0; i < 2000 && q[0] !== 1'b1; i = i + 1) rd(`ADCSQ_A_STAT);
			chk("flag", 16'h0001, q[0]);
			chk("irqoff", 16'h0000, IRQ_O);
			chk("wptr", w0[12:9] + 4'h1, q[12:9]);
			chk("wake", 16'h0001, tr - tp >= 20 * tk - 1 && tr - tp <= 21 * tk);
			chk("acq", acq * tk, tf - tr);
			chk("conv", 16'h0001, cyc - tf >= 34 * tk && cyc - tf <= 35 * tk + 8);
			rd(`ADCSQ_A_RESULT);
			chk("code", 16'h015A, q[11:0]);
			repeat (8 * tk + 4) @(posedge CLK_I);
			rd(`ADCSQ_A_CTRL);
			chk("single", 16'h0000, {q[0], CONV_PWR_O});
		end
	endtask
	initial begin
		rows[0] = {1'b0, `ADCSQ_A_CTRL, 16'h0000, `ADCSQ_CTRL_RST};
		rows[1] = {1'b0, `ADCSQ_A_GLO, 16'h0000, `ADCSQ_GAIN_RST};
		rows[2] = {1'b0, `ADCSQ_A_GHI, 16'h0000, `ADCSQ_GAIN_RST};
		rows[3] = {1'b0, `ADCSQ_A_IEN, 16'h0000, 16'h0000};
		rows[4] = {1'b1, `ADCSQ_A_GLO, 16'h1234, 16'h1234};
		rows[5] = {1'b1, `ADCSQ_A_GHI, 16'h0ABC, 16'h0ABC};
		rows[6] = {1'b1, `ADCSQ_A_STAT, 16'hFFFF, 16'h0000};
		rows[7] = {1'b1, 5'h07, 16'hFFFF, 16'h0000};
		rows[8] = {1'b1, `ADCSQ_A_CFG0 + 5'h07, 16'h0735, 16'h0735};
		repeat (4) @(posedge CLK_I);
		RST_B_I <= 1;
		for (i = 0; i < 9; i = i + 1) begin
			if (rows[i][37]) wr(rows[i][36:32], rows[i][31:16]);
			rd(rows[i][36:32]);
			chk("reg", rows[i][15:0], q);
		end
		run(16'h0140, 16'h0001, 16, 4);
		wr(`ADCSQ_A_IEN, 16'h0001);
		repeat (2) @(posedge CLK_I);
		chk("irqon", 16'h0001, IRQ_O);
		wr(`ADCSQ_A_IEN, 16'h0000);
		run(16'h0144, 16'h0045, 32, 6);
		wr(`ADCSQ_A_CFG0, 16'h0669);
		rd(`ADCSQ_A_STAT);
		w0 = q;
		wr(`ADCSQ_A_CTRL, 16'h0001);
		for (k = 0; k < 3; k = k + 1) begin
			for (i = 0; i < 2000 && SAMPLE_O !== 1'b1; i = i + 1) @(negedge CLK_I);
			chk("bias", k[15:0], {dif, ext, fsh, bias});
			chk("tgain", 16'h1234, GAIN_O);
			for (i = 0; i < 2000 && SAMPLE_O !== 1'b0; i = i + 1) @(negedge CLK_I);
		end
		q = 0;
		for (i = 0; i < 2000 && q[0] !== 1'b1; i = i + 1) rd(`ADCSQ_A_STAT);
		chk("tptr", w0[12:9] + 4'h1, q[12:9]);
		rd(`ADCSQ_A_RESULT);
		chk("tcode", 16'h065A, q[12:0]);
		wr(`ADCSQ_A_IEN, 16'h0001);
		wr(`ADCSQ_A_ICLR, 16'h0001);
		repeat (2) @(posedge CLK_I);
		rd(`ADCSQ_A_STAT);
		chk("clear", 16'h0000, {q[0], IRQ_O});
		wr(`ADCSQ_A_CTRL, 16'h0003);
		repeat (400) @(posedge CLK_I);
		STOP_I <= 1;
		repeat (10) @(posedge CLK_I);
		wr(`ADCSQ_A_CTRL, 16'h0001);
		rd(`ADCSQ_A_CTRL);
		chk("stop", 16'h0000, {q[0], CONV_PWR_O, SAMPLE_O});
		STOP_I <= 0;
		repeat (10) @(posedge CLK_I);
		chk("idle", 16'h0000, CONV_PWR_O);
		RST_B_I <= 0;
		repeat (2) @(posedge CLK_I);
		RST_B_I <= 1;
		rd(`ADCSQ_A_GLO);
		chk("reset", 16'h0001, q === `ADCSQ_GAIN_RST && GAIN_O === `ADCSQ_GAIN_RST && IRQ_O === 1'b0);
		conclude;
	end
endmodule
bind adcsq_top adcsq_asserts chk_u (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
	.WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .STOP_I(STOP_I), .MUX_SEL_O(MUX_SEL_O),
	.EXT_REF_O(EXT_REF_O), .FS_HIGH_O(FS_HIGH_O), .SAMPLE_O(SAMPLE_O), .CONV_PWR_O(CONV_PWR_O), .IRQ_O(IRQ_O));
